/* shared/lbs_pkg.sv */
// constants and types shared by the led boost protection sequencer
package lbs_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int LBS_CLK_PERIOD_NS  = 10;
	localparam int LBS_OLP_FORCE_NS   = 5000;
	localparam int LBS_OVP_TRIP_NS    = 20000;
	localparam int LBS_OVP_REL_NS     = 14000;
	localparam int LBS_OCP_DELAY_NS   = 1000;
	localparam int LBS_EDGE_BLANK_NS  = 300;
	localparam int LBS_OLP_FORCE_CYC  = (LBS_OLP_FORCE_NS + LBS_CLK_PERIOD_NS - 1) / LBS_CLK_PERIOD_NS;
	localparam int LBS_OVP_TRIP_CYC   = (LBS_OVP_TRIP_NS + LBS_CLK_PERIOD_NS - 1) / LBS_CLK_PERIOD_NS;
	localparam int LBS_OVP_REL_CYC    = (LBS_OVP_REL_NS + LBS_CLK_PERIOD_NS - 1) / LBS_CLK_PERIOD_NS;
	localparam int LBS_OCP_DELAY_CYC  = (LBS_OCP_DELAY_NS + LBS_CLK_PERIOD_NS - 1) / LBS_CLK_PERIOD_NS;
	localparam int LBS_EDGE_BLANK_CYC = (LBS_EDGE_BLANK_NS + LBS_CLK_PERIOD_NS - 1) / LBS_CLK_PERIOD_NS;
	localparam logic [9:0]  LBS_SS_PERIODS    = 10'd600;
	localparam logic [13:0] LBS_OLP_BLANK_PER = 14'd8192;
	localparam logic [7:0]  LBS_AR_PERIODS    = 8'd128;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] LBS_ADDR_CTRL   = 8'h00;
	localparam logic [7:0] LBS_ADDR_STATUS = 8'h04;
	localparam logic [7:0] LBS_ADDR_SSCNT  = 8'h08;
	localparam int   LBS_CTRL_RUN_BIT = 0;
	localparam logic LBS_CTRL_RUN_RST = 1'b1;
	localparam int LBS_ST_FAULT_BIT = 0;
	localparam int LBS_ST_OVP_BIT   = 1;
	localparam int LBS_ST_OCP_BIT   = 2;
	localparam int LBS_ST_FORCE_BIT = 3;
	localparam int LBS_ST_SOFT_BIT  = 4;
	localparam int LBS_ST_RUN_BIT   = 5;
	localparam int LBS_ST_ARMED_BIT = 6;
	localparam int LBS_ST_CLIM_BIT  = 7;

	// ------------------------------------------------------------
	// pin indexes
	// ------------------------------------------------------------
	localparam int LBS_NPIN      = 10;
	localparam int LBS_PIN_EN    = 0;
	localparam int LBS_PIN_LOCK  = 1;
	localparam int LBS_PIN_REF   = 2;
	localparam int LBS_PIN_DIM   = 3;
	localparam int LBS_PIN_OSC   = 4;
	localparam int LBS_PIN_OPEN  = 5;
	localparam int LBS_PIN_OVPT  = 6;
	localparam int LBS_PIN_OVPC  = 7;
	localparam int LBS_PIN_OCP   = 8;
	localparam int LBS_PIN_CS    = 9;

	typedef enum logic [2:0]
	{
		LBS_ST_OFF  = 3'b001,
		LBS_ST_SOFT = 3'b010,
		LBS_ST_RUN  = 3'b100
	} lbs_state_t;

endpackage

/* shared/lbs_pin_if.sv */
// synchronised pin levels passed from the synchroniser to the sequencer
`timescale 1ns/100ps
`default_nettype none
interface lbs_pin_if;
	import lbs_pkg::*;
	logic [LBS_NPIN-1:0] lvl;
	modport drv (output lvl);
	modport use_mp (input lvl);
endinterface
`default_nettype wire

/* src/lbs_sync.sv */
// two-flop synchroniser for all asynchronous pin inputs
`timescale 1ns/100ps
`default_nettype none
module lbs_sync
	import lbs_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                rst,
	input  wire logic [LBS_NPIN-1:0] raw,
	lbs_pin_if.drv                   pins
);
	logic [LBS_NPIN-1:0] meta_r;
	logic [LBS_NPIN-1:0] stab_r;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			meta_r <= '0;
			stab_r <= '0;
		end
		else
		begin
			meta_r <= raw;
			stab_r <= meta_r;
		end
	end

	assign pins.lvl = stab_r;
endmodule
`default_nettype wire

/* src/lbs_qual.sv */
// persistence timer: hit once cond has held for COUNT cycles
`timescale 1ns/100ps
`default_nettype none
module lbs_qual
	import lbs_pkg::*;
#(
	parameter int COUNT = 1
)(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic clr,
	input  wire logic cond,
	output logic      hit
);
	localparam logic [11:0] LIM = 12'(COUNT - 1);
	logic [11:0] cnt_r;

	always_ff @(posedge clk)
	begin
		if (rst || clr || !cond)
			cnt_r <= 12'h000;
		else if (cnt_r != LIM)
			cnt_r <= cnt_r + 12'h001;
	end

	assign hit = cond && !clr && (cnt_r == LIM);

	a_hit_needs_hold: assert property (@(posedge clk) disable iff (rst)
		hit && (COUNT > 2) |-> $past(cond) && $past(cond, 2))
		else $error("persistence hit without held condition");
endmodule
`default_nettype wire

/* src/lbs_seq.sv */
// led boost driver sequencing, protection and apb status
//
// The address map and register access over APB were decided locally.
`timescale 1ns/100ps
`default_nettype none
module lbs_seq
	import lbs_pkg::*;
(
	input  wire logic        SYS_CLK,
	input  wire logic        RESET,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        ENABLE_INPUT,
	input  wire logic        SUPPLY_LOCKOUT,
	input  wire logic        REF_READY,
	input  wire logic        PWM_DIM_INPUT,
	input  wire logic        OSC_IN,
	input  wire logic        OPEN_DET,
	input  wire logic        OVP_TRIP,
	input  wire logic        OVP_CLEAR,
	input  wire logic        LED_OCP_DET,
	input  wire logic        CS_LIMIT_DET,
	output logic             REF_ENABLE,
	output logic             BOOST_GATE,
	output logic             DIM_GATE,
	output logic             GM_CONNECT,
	output logic             SS_CLAMP,
	output logic             FAULT_OUT_O,
	output logic             FAULT_OUT_OE_N
);

	// ------------------------------------------------------------
	// pin synchronisation
	// ------------------------------------------------------------
	lbs_pin_if pins ();
	logic [LBS_NPIN-1:0] raw_pins;

	assign raw_pins[LBS_PIN_EN]   = ENABLE_INPUT;
	assign raw_pins[LBS_PIN_LOCK] = SUPPLY_LOCKOUT;
	assign raw_pins[LBS_PIN_REF]  = REF_READY;
	assign raw_pins[LBS_PIN_DIM]  = PWM_DIM_INPUT;
	assign raw_pins[LBS_PIN_OSC]  = OSC_IN;
	assign raw_pins[LBS_PIN_OPEN] = OPEN_DET;
	assign raw_pins[LBS_PIN_OVPT] = OVP_TRIP;
	assign raw_pins[LBS_PIN_OVPC] = OVP_CLEAR;
	assign raw_pins[LBS_PIN_OCP]  = LED_OCP_DET;
	assign raw_pins[LBS_PIN_CS]   = CS_LIMIT_DET;

	lbs_sync u_sync
	(
		.clk  (SYS_CLK),
		.rst  (RESET),
		.raw  (raw_pins),
		.pins (pins)
	);

	logic en_s;
	logic lock_s;
	logic ref_s;
	logic dim_s;
	logic osc_s;
	logic open_s;
	logic ovpt_s;
	logic ovpc_s;
	logic ocp_s;
	logic cs_s;

	assign en_s   = pins.lvl[LBS_PIN_EN];
	assign lock_s = pins.lvl[LBS_PIN_LOCK];
	assign ref_s  = pins.lvl[LBS_PIN_REF];
	assign dim_s  = pins.lvl[LBS_PIN_DIM];
	assign osc_s  = pins.lvl[LBS_PIN_OSC];
	assign open_s = pins.lvl[LBS_PIN_OPEN];
	assign ovpt_s = pins.lvl[LBS_PIN_OVPT];
	assign ovpc_s = pins.lvl[LBS_PIN_OVPC];
	assign ocp_s  = pins.lvl[LBS_PIN_OCP];
	assign cs_s   = pins.lvl[LBS_PIN_CS];

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	lbs_state_t  state_r;
	lbs_state_t  state_nxt;
	logic        ctrl_run_r;
	logic        osc_d_r;
	logic        osc_tick;
	logic        go;
	logic        active;
	logic [9:0]  ss_cnt_r;
	logic        ss_done;
	logic        armed_r;
	logic        olp_force_r;
	logic        olp_cond;
	logic        olp_hit;
	logic [13:0] olp_blank_r;
	logic        fault_r;
	logic        ovp_r;
	logic        ovp_trip_hit;
	logic        ovp_rel_hit;
	logic        ocp_off_r;
	logic        ocp_hit;
	logic [7:0]  ar_cnt_r;
	logic        dim_int;
	logic        allow;
	logic        bon_r;
	logic        blank_done;
	logic        cs_trip;
	logic        clim_r;
	logic        boost_gate_r;
	logic        dim_gate_r;
	logic        gm_r;
	logic        ss_clamp_r;
	logic        fault_oe_n_r;
	logic        ref_en_r;
	logic [31:0] prdata_r;

	// ------------------------------------------------------------
	// oscillator period tick
	// ------------------------------------------------------------
	always_ff @(posedge SYS_CLK)
	begin
		if (RESET)
			osc_d_r <= 1'b0;
		else
			osc_d_r <= osc_s;
	end

	assign osc_tick = osc_s && !osc_d_r;

	// ------------------------------------------------------------
	// enable, lockout and state
	// ------------------------------------------------------------
	assign go     = en_s && !lock_s && ref_s && ctrl_run_r;
	assign active = (state_r != LBS_ST_OFF);

	always_ff @(posedge SYS_CLK)
	begin
		if (RESET)
			ref_en_r <= 1'b0;
		else
			ref_en_r <= en_s && !lock_s && ctrl_run_r;
	end

	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			LBS_ST_OFF:
				if (go)
					state_nxt = LBS_ST_SOFT;
			LBS_ST_SOFT:
				if (!go)
					state_nxt = LBS_ST_OFF;
				else if (ss_done)
					state_nxt = LBS_ST_RUN;
			LBS_ST_RUN:
				if (!go)
					state_nxt = LBS_ST_OFF;
			default:
				state_nxt = LBS_ST_OFF;
		endcase
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (RESET)
			state_r <= LBS_ST_OFF;
		else
			state_r <= state_nxt;
	end

	// ------------------------------------------------------------
	// soft-start
	// ------------------------------------------------------------
	assign ss_done = (ss_cnt_r == LBS_SS_PERIODS);

	always_ff @(posedge SYS_CLK)
	begin
		if (RESET || !active)
			ss_cnt_r <= 10'h000;
		else if (state_r == LBS_ST_SOFT && osc_tick && dim_int && !ss_done)
			ss_cnt_r <= ss_cnt_r + 10'h001;
	end

	// ------------------------------------------------------------
	// open-string protection
	// ------------------------------------------------------------
	always_ff @(posedge SYS_CLK)
	begin
		if (RESET || !active)
			armed_r <= 1'b0;
		else if (dim_s)
			armed_r <= 1'b1;
	end

	assign dim_int  = dim_s || olp_force_r;
	assign olp_cond = active && armed_r && dim_int && open_s;

	lbs_qual #(.COUNT(LBS_OLP_FORCE_CYC)) u_olp
	(
		.clk  (SYS_CLK),
		.rst  (RESET),
		.clr  (!active),
		.cond (olp_cond),
		.hit  (olp_hit)
	);

	always_ff @(posedge SYS_CLK)
	begin
		if (RESET)
			olp_force_r <= 1'b0;
		else
			olp_force_r <= olp_hit;
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (RESET || !olp_cond)
			olp_blank_r <= 14'h0000;
		else if (osc_tick && olp_blank_r != LBS_OLP_BLANK_PER)
			olp_blank_r <= olp_blank_r + 14'h0001;
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (RESET || !active)
			fault_r <= 1'b0;
		else if (olp_blank_r == LBS_OLP_BLANK_PER)
			fault_r <= 1'b1;
	end

	// ------------------------------------------------------------
	// over-voltage protection
	// ------------------------------------------------------------
	lbs_qual #(.COUNT(LBS_OVP_TRIP_CYC)) u_ovp_trip
	(
		.clk  (SYS_CLK),
		.rst  (RESET),
		.clr  (!active),
		.cond (ovpt_s),
		.hit  (ovp_trip_hit)
	);

	lbs_qual #(.COUNT(LBS_OVP_REL_CYC)) u_ovp_rel
	(
		.clk  (SYS_CLK),
		.rst  (RESET),
		.clr  (!active),
		.cond (ovpc_s),
		.hit  (ovp_rel_hit)
	);

	always_ff @(posedge SYS_CLK)
	begin
		if (RESET || !active)
			ovp_r <= 1'b0;
		else if (ovp_trip_hit)
			ovp_r <= 1'b1;
		else if (ovp_rel_hit)
			ovp_r <= 1'b0;
	end

	// ------------------------------------------------------------
	// led over-current with auto-restart
	// ------------------------------------------------------------
	lbs_qual #(.COUNT(LBS_OCP_DELAY_CYC)) u_ocp
	(
		.clk  (SYS_CLK),
		.rst  (RESET),
		.clr  (!active || ocp_off_r),
		.cond (ocp_s),
		.hit  (ocp_hit)
	);

	always_ff @(posedge SYS_CLK)
	begin
		if (RESET || !active)
			ocp_off_r <= 1'b0;
		else if (ocp_hit)
			ocp_off_r <= 1'b1;
		else if (osc_tick && ar_cnt_r == LBS_AR_PERIODS - 8'h01)
			ocp_off_r <= 1'b0;
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (RESET || !ocp_off_r)
			ar_cnt_r <= 8'h00;
		else if (osc_tick)
			ar_cnt_r <= ar_cnt_r + 8'h01;
	end

	// ------------------------------------------------------------
	// boost on-time and current limit
	// ------------------------------------------------------------
	assign allow = active && dim_int && !ovp_r && !ocp_off_r;

	lbs_qual #(.COUNT(LBS_EDGE_BLANK_CYC)) u_edge_blanking
	(
		.clk  (SYS_CLK),
		.rst  (RESET),
		.clr  (!allow),
		.cond (bon_r),
		.hit  (blank_done)
	);

	assign cs_trip = bon_r && blank_done && cs_s;

	always_ff @(posedge SYS_CLK)
	begin
		if (RESET || !allow)
			bon_r <= 1'b0;
		else if (osc_tick)
			bon_r <= 1'b1;
		else if (cs_trip)
			bon_r <= 1'b0;
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (RESET)
			clim_r <= 1'b0;
		else if (cs_trip)
			clim_r <= 1'b1;
		else if (osc_tick)
			clim_r <= 1'b0;
	end

	// ------------------------------------------------------------
	// output drive
	// ------------------------------------------------------------
	always_ff @(posedge SYS_CLK)
	begin
		if (RESET)
		begin
			boost_gate_r <= 1'b0;
			dim_gate_r   <= 1'b0;
			gm_r         <= 1'b0;
			ss_clamp_r   <= 1'b0;
			fault_oe_n_r <= 1'b0;
		end
		else
		begin
			boost_gate_r <= allow && bon_r;
			dim_gate_r   <= allow;
			gm_r         <= active && dim_int;
			ss_clamp_r   <= (state_r == LBS_ST_SOFT);
			fault_oe_n_r <= fault_r;
		end
	end

	assign BOOST_GATE     = boost_gate_r;
	assign DIM_GATE       = dim_gate_r;
	assign GM_CONNECT     = gm_r;
	assign SS_CLAMP       = ss_clamp_r;
	assign REF_ENABLE     = ref_en_r;
	assign FAULT_OUT_O    = 1'b0;
	assign FAULT_OUT_OE_N = fault_oe_n_r;

	// ------------------------------------------------------------
	// apb slave
	// ------------------------------------------------------------
	logic apb_setup;
	logic apb_access;
	logic addr_ok;

	assign apb_setup  = PSEL && !PENABLE;
	assign apb_access = PSEL && PENABLE;
	assign addr_ok    = (PADDR == LBS_ADDR_CTRL) || (PADDR == LBS_ADDR_STATUS)
		|| (PADDR == LBS_ADDR_SSCNT);
	assign PREADY     = 1'b1;
	assign PSLVERR    = apb_access && !addr_ok;
	assign PRDATA     = prdata_r;

	always_ff @(posedge SYS_CLK)
	begin
		if (RESET)
			ctrl_run_r <= LBS_CTRL_RUN_RST;
		else if (apb_access && PWRITE && PADDR == LBS_ADDR_CTRL)
			ctrl_run_r <= PWDATA[LBS_CTRL_RUN_BIT];
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (RESET)
			prdata_r <= 32'h0000_0000;
		else if (apb_setup)
		begin
			prdata_r <= 32'h0000_0000;
			if (PADDR == LBS_ADDR_CTRL)
				prdata_r[LBS_CTRL_RUN_BIT] <= ctrl_run_r;
			else if (PADDR == LBS_ADDR_STATUS)
			begin
				prdata_r[LBS_ST_FAULT_BIT] <= fault_r;
				prdata_r[LBS_ST_OVP_BIT]   <= ovp_r;
				prdata_r[LBS_ST_OCP_BIT]   <= ocp_off_r;
				prdata_r[LBS_ST_FORCE_BIT] <= olp_force_r;
				prdata_r[LBS_ST_SOFT_BIT]  <= (state_r == LBS_ST_SOFT);
				prdata_r[LBS_ST_RUN_BIT]   <= (state_r == LBS_ST_RUN);
				prdata_r[LBS_ST_ARMED_BIT] <= armed_r;
				prdata_r[LBS_ST_CLIM_BIT]  <= clim_r;
			end
			else if (PADDR == LBS_ADDR_SSCNT)
				prdata_r[9:0] <= ss_cnt_r;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RESET);

	sequence s_ocp_trip;
		ocp_hit ##1 ocp_off_r;
	endsequence

	sequence s_cs_cut;
		cs_trip && !osc_tick ##1 !osc_tick;
	endsequence

	a_dim_low_off: assert property (!dim_int |=> !DIM_GATE && !BOOST_GATE && !GM_CONNECT)
		else $error("gates on while dimming low");
	a_ss_length: assert property ($rose(state_r == LBS_ST_RUN) |-> $past(ss_cnt_r) == LBS_SS_PERIODS)
		else $error("soft-start ended at wrong count");
	a_ss_clamp: assert property (state_r == LBS_ST_SOFT |=> SS_CLAMP)
		else $error("clamp missing in soft-start");
	a_olp_unarmed: assert property (!armed_r |=> !olp_force_r)
		else $error("dimming forced before arming");
	a_olp_force: assert property ($rose(olp_force_r) |-> $past(olp_cond) && $past(olp_cond, 2))
		else $error("dimming forced without open string");
	a_fault_cause: assert property ($rose(fault_r) |-> $past(olp_blank_r) == LBS_OLP_BLANK_PER)
		else $error("fault raised before blanking");
	a_fault_pin: assert property (!fault_r ##1 !fault_r |-> !FAULT_OUT_OE_N)
		else $error("fault pin released without fault");
	a_fault_only_olp: assert property (ovp_r && !fault_r |=> !FAULT_OUT_OE_N)
		else $error("over-voltage drove fault pin");
	a_ovp_off: assert property (ovp_r |=> !DIM_GATE && !BOOST_GATE)
		else $error("gates on during over-voltage");
	a_ovp_qual: assert property ($rose(ovp_r) |-> $past(ovpt_s) && $past(ovpt_s, 3))
		else $error("over-voltage taken without qualification");
	a_ocp_off: assert property (s_ocp_trip |=> !BOOST_GATE && !DIM_GATE)
		else $error("gates on after over-current");
	a_edge_blank: assert property ($rose(bon_r) |-> !cs_trip [*8])
		else $error("current limit inside blanking");
	a_cs_cut: assert property (s_cs_cut |=> !BOOST_GATE)
		else $error("boost on after current limit");
	a_off_clears: assert property (!active |=> ss_cnt_r == 10'h000 && !ovp_r && !ocp_off_r
		&& !fault_r)
		else $error("state kept while disabled");
endmodule
`default_nettype wire

/* verif/lbs_stage_model.sv */
// boost stage, led string and current sense model
`timescale 1ns/100ps
`default_nettype none
module lbs_stage_model
(
	input  wire logic       clk,
	input  wire logic [7:0] osc_half,
	input  wire logic [7:0] cs_at,
	input  wire logic       open_cmd,
	input  wire logic       boost_gate,
	output logic            osc,
	output logic            open_det,
	output logic            cs_det
);
	// ------------------------------------------------------------
	// oscillator and switch current
	// ------------------------------------------------------------
	logic [7:0] ph_r = 8'h00;
	logic [7:0] on_r = 8'h00;
	initial osc = 1'b0;
	always @(posedge clk)
	begin
		if (ph_r + 8'h01 >= osc_half)
		begin
			ph_r <= 8'h00;
			osc  <= ~osc;
		end
		else
			ph_r <= ph_r + 8'h01;
	end
	// current ramps only while the switch is on
	always @(posedge clk)
		on_r <= !boost_gate ? 8'h00 : ((on_r == 8'hFF) ? on_r : on_r + 8'h01);
	assign cs_det   = boost_gate && (on_r >= cs_at);
	assign open_det = open_cmd;
endmodule
`default_nettype wire

/* verif/tb.sv */
// self-checking testbench for the sequencer
`timescale 1ns/100ps
`default_nettype none
module tb
	import lbs_pkg::*;
;
	logic        SYS_CLK = 1'b0, RESET = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
	logic [7:0]  PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0;
	logic        ENABLE_INPUT = 1'b0, SUPPLY_LOCKOUT = 1'b1, REF_READY = 1'b0, PWM_DIM_INPUT = 1'b0;
	logic        OVP_TRIP = 1'b0, OVP_CLEAR = 1'b1, LED_OCP_DET = 1'b0, open_cmd = 1'b0;
	logic [7:0]  osc_half = 8'h04, cs_at = 8'hFF;
	wire logic [31:0] PRDATA;
	wire logic   PREADY, PSLVERR, REF_ENABLE, BOOST_GATE, DIM_GATE, GM_CONNECT, SS_CLAMP;
	wire logic   FAULT_OUT_O, FAULT_OUT_OE_N, OSC_IN, OPEN_DET, CS_LIMIT_DET;
	// external pull-up on the open-drain fault pin
	wire logic   fault_pin = FAULT_OUT_OE_N ? 1'b1 : FAULT_OUT_O;
	int          err_count = 0, checks_done = 0, ticks = 0, n;
	logic        osc_q = 1'b0, er;
	logic [31:0] rd;

	always #5 SYS_CLK = ~SYS_CLK;
	always @(posedge SYS_CLK)
	begin
		osc_q <= OSC_IN;
		if (OSC_IN && !osc_q)
			ticks <= ticks + 1;
	end

	lbs_seq dut (.SYS_CLK(SYS_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
		.PSLVERR(PSLVERR), .ENABLE_INPUT(ENABLE_INPUT), .SUPPLY_LOCKOUT(SUPPLY_LOCKOUT),
		.REF_READY(REF_READY), .PWM_DIM_INPUT(PWM_DIM_INPUT), .OSC_IN(OSC_IN),
		.OPEN_DET(OPEN_DET), .OVP_TRIP(OVP_TRIP), .OVP_CLEAR(OVP_CLEAR),
		.LED_OCP_DET(LED_OCP_DET), .CS_LIMIT_DET(CS_LIMIT_DET), .REF_ENABLE(REF_ENABLE),
		.BOOST_GATE(BOOST_GATE), .DIM_GATE(DIM_GATE), .GM_CONNECT(GM_CONNECT),
		.SS_CLAMP(SS_CLAMP), .FAULT_OUT_O(FAULT_OUT_O), .FAULT_OUT_OE_N(FAULT_OUT_OE_N));
	lbs_stage_model bfm (.clk(SYS_CLK), .osc_half(osc_half), .cs_at(cs_at),
		.open_cmd(open_cmd), .boost_gate(BOOST_GATE), .osc(OSC_IN), .open_det(OPEN_DET),
		.cs_det(CS_LIMIT_DET));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e)
		begin
			$display("ERROR %s expected %0h seen %0h", nm, e, s);
			err_count++;
		end
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task cyc(input int c);
		repeat (c) @(posedge SYS_CLK);
		#1;
	endtask
	task wait_ticks(input int c);
		int t0;
		int k;
		t0 = ticks;
		k = 0;
		while (ticks - t0 < c && k < 100000)
		begin
			@(posedge SYS_CLK);
			k++;
		end
		if (k >= 100000)
		begin
			err_count++;
			print_verdict;
		end
		#1;
	endtask
	task wait_gate(input logic v, output int c);
		c = 0;
		do
		begin
			@(posedge SYS_CLK);
			#1;
			c++;
		end
		while (BOOST_GATE !== v && c < 200);
		if (c >= 200)
		begin
			err_count++;
			print_verdict;
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		int k;
		@(posedge SYS_CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge SYS_CLK);
		PENABLE <= 1'b1;
		k = 0;
		do
		begin
			@(posedge SYS_CLK);
			k++;
		end
		while (PREADY !== 1'b1 && k < 50);
		if (k >= 50)
		begin
			err_count++;
			print_verdict;
		end
		r = PRDATA;
		e = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task t_apb;
		#1;
		chk("fault_pin", fault_pin, 0);
		apb(1'b0, LBS_ADDR_CTRL, 32'h0, rd, er);
		chk("ctrl", rd, 32'h1);
		apb(1'b1, 8'h0C, 32'hFFFFFFFF, rd, er);
		chk("unmapped_err", er, 1);
		apb(1'b1, LBS_ADDR_STATUS, 32'hFF, rd, er);
		chk("ro_err", er, 0);
		apb(1'b0, LBS_ADDR_STATUS, 32'h0, rd, er);
		chk("status", rd, 32'h0);
		$display("test apb done");
	endtask
	task t_start;
		@(posedge SYS_CLK) ENABLE_INPUT <= 1'b1;
		cyc(10);
		chk("ref_lock", REF_ENABLE, 0);
		@(posedge SYS_CLK) SUPPLY_LOCKOUT <= 1'b0;
		PWM_DIM_INPUT <= 1'b1;
		cyc(10);
		chk("ref_on", REF_ENABLE, 1);
		chk("dim_noref", DIM_GATE, 0);
		@(posedge SYS_CLK) PWM_DIM_INPUT <= 1'b0;
		REF_READY <= 1'b1;
		cyc(10);
		chk("clamp", SS_CLAMP, 1);
		chk("gm_low", GM_CONNECT, 0);
		@(posedge SYS_CLK) PWM_DIM_INPUT <= 1'b1;
		wait_ticks(300);
		chk("dim_high", DIM_GATE, 1);
		chk("gm_high", GM_CONNECT, 1);
		@(posedge SYS_CLK) PWM_DIM_INPUT <= 1'b0;
		wait_ticks(100);
		chk("dim_low", DIM_GATE, 0);
		@(posedge SYS_CLK) PWM_DIM_INPUT <= 1'b1;
		wait_ticks(290);
		chk("ss_590", SS_CLAMP, 1);
		wait_ticks(15);
		chk("ss_605", SS_CLAMP, 0);
		$display("test start done");
	endtask
	task t_prot;
		@(posedge SYS_CLK) OVP_TRIP <= 1'b1;
		OVP_CLEAR <= 1'b0;
		cyc(1950);
		chk("ovp_early", DIM_GATE, 1);
		cyc(100);
		chk("ovp_dim", DIM_GATE, 0);
		chk("ovp_boost", BOOST_GATE, 0);
		chk("ovp_pin", fault_pin, 0);
		@(posedge SYS_CLK) OVP_TRIP <= 1'b0;
		OVP_CLEAR <= 1'b1;
		cyc(1350);
		chk("ovp_hold", DIM_GATE, 0);
		cyc(100);
		chk("ovp_rel", DIM_GATE, 1);
		@(posedge SYS_CLK) LED_OCP_DET <= 1'b1;
		cyc(90);
		chk("ocp_early", DIM_GATE, 1);
		cyc(20);
		chk("ocp_dim", DIM_GATE, 0);
		chk("ocp_boost", BOOST_GATE, 0);
		chk("ocp_pin", fault_pin, 0);
		@(posedge SYS_CLK) LED_OCP_DET <= 1'b0;
		wait_ticks(118);
		chk("ar_hold", DIM_GATE, 0);
		wait_ticks(14);
		chk("ar_retry", DIM_GATE, 1);
		$display("test protection done");
	endtask
	task t_climit;
		@(posedge SYS_CLK) osc_half <= 8'h28;
		cs_at <= 8'h05;
		wait_gate(1'b0, n);
		wait_gate(1'b1, n);
		wait_gate(1'b0, n);
		chk("blank", (n >= 30 && n <= 36), 1);
		wait_gate(1'b1, n);
		chk("off_rest", (n >= 40 && n <= 52), 1);
		@(posedge SYS_CLK) osc_half <= 8'h04;
		cs_at <= 8'hFF;
		$display("test current limit done");
	endtask
	task t_ctrl;
		apb(1'b1, LBS_ADDR_CTRL, 32'h0, rd, er);
		cyc(5);
		chk("run_off", REF_ENABLE, 0);
		apb(1'b1, LBS_ADDR_CTRL, 32'h1, rd, er);
		@(posedge SYS_CLK) ENABLE_INPUT <= 1'b0;
		cyc(10);
		chk("disable", REF_ENABLE, 0);
		apb(1'b0, LBS_ADDR_SSCNT, 32'h0, rd, er);
		chk("sscnt_clr", rd, 32'h0);
		@(posedge SYS_CLK) ENABLE_INPUT <= 1'b1;
		cyc(10);
		chk("ss_again", SS_CLAMP, 1);
		$display("test control done");
	endtask
	task t_open;
		@(posedge SYS_CLK) PWM_DIM_INPUT <= 1'b0;
		open_cmd <= 1'b1;
		cyc(700);
		chk("open_dimlow", DIM_GATE, 0);
		@(posedge SYS_CLK) PWM_DIM_INPUT <= 1'b1;
		cyc(530);
		@(posedge SYS_CLK) PWM_DIM_INPUT <= 1'b0;
		cyc(10);
		chk("forced", DIM_GATE, 1);
		wait_ticks(8000);
		chk("olp_early", fault_pin, 0);
		wait_ticks(200);
		chk("olp_fault", fault_pin, 1);
		// system answers the fault by removing power
		@(posedge SYS_CLK) SUPPLY_LOCKOUT <= 1'b1;
		cyc(10);
		chk("lock_ref", REF_ENABLE, 0);
		chk("lock_pin", fault_pin, 0);
		$display("test open string done");
	endtask

	initial
	begin
		repeat (3) @(posedge SYS_CLK);
		RESET <= 1'b0;
		t_apb;
		t_start;
		t_prot;
		t_climit;
		t_ctrl;
		t_open;
		print_verdict;
	end
endmodule
`default_nettype wire
